// *** dv/oscsel_osc_model.sv ***
// Behavioural crystal and sub-oscillator sources driving the clock block pins
`timescale 1ns/1ns
module oscsel_osc_model
#(
    parameter XT_HALF = 2,
    parameter SUB_HALF = 2
)
(
    input wire mclk,
    input wire xt_en,
    input wire sub_en,
    output reg xt_clk,
    output reg sub_clk
);
    integer xt_cnt;
    integer sub_cnt;
    initial
    begin
        xt_clk = 1'b0;
        sub_clk = 1'b0;
        xt_cnt = 0;
        sub_cnt = 0;
    end
    // A stopped oscillator rests low; larger half periods model a slower oscillator
    always @(posedge mclk)
    begin
        // An enable still unknown before reset counts as stopped, so no count turns unknown
        xt_cnt <= (xt_en !== 1'b1 || xt_cnt == XT_HALF - 1) ? 0 : xt_cnt + 1;
        sub_cnt <= (sub_en !== 1'b1 || sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
        if (xt_en !== 1'b1)
            xt_clk <= 1'b0;
        else if (xt_cnt == XT_HALF - 1)
            xt_clk <= ~xt_clk;
        if (sub_en !== 1'b1)
            sub_clk <= 1'b0;
        else if (sub_cnt == SUB_HALF - 1)
            sub_clk <= ~sub_clk;
    end
endmodule

// *** dv/oscsel_top_asserts.sv ***
// Concurrent checks on the ports of the clock source block
`timescale 1ns/1ns
module oscsel_top_asserts
#(
    parameter XTAL_LONG_CNT = 65536,
    parameter SUB_LONG_CNT = 65536
)
(
    input wire mclk,
    input wire sys_rst,
    input wire pin_rst,
    input wire wdt_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire pd_enter,
    input wire int_ack_hi,
    input wire int_ack_lo,
    input wire return_from_interrupt,
    input wire crystal_osc_en,
    input wire sub_osc_en,
    input wire cpu_hold,
    input wire high_prio_in_service,
    input wire low_prio_in_service
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Secondary resets rewrite state, so event checks skip those cycles
    wire quiet = !pin_rst && !wdt_rst;

    a_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside the read slot");
    a_unmapped_zero:
        assert property ($past(reg_rd) && ($past(reg_addr) < 8'hC4 || $past(reg_addr) > 8'hC8)
            |-> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_mode_fixed_bits:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'hC4 |-> reg_rdata[2:0] == 3'h1)
        else $error("mode register low bits wrong");
    a_status_service_mirror:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'hC5 |-> reg_rdata[3:0] == 4'h0
            && reg_rdata[6:5] == {$past(high_prio_in_service), $past(low_prio_in_service)})
        else $error("status in-service bits disagree with outputs");
    a_ack_hi_sets:
        assert property (int_ack_hi && quiet |=> high_prio_in_service)
        else $error("high in-service not set after ack");
    a_ack_lo_sets:
        assert property (int_ack_lo && quiet |=> low_prio_in_service)
        else $error("low in-service not set after ack");
    a_return_clears_high:
        assert property (return_from_interrupt && high_prio_in_service && !int_ack_hi
            && !int_ack_lo && quiet |=> !high_prio_in_service && $stable(low_prio_in_service))
        else $error("return did not clear only the high in-service bit");
    a_pd_holds_cpu:
        assert property (pd_enter && quiet |-> ##[1:2] (cpu_hold && !crystal_osc_en))
        else $error("power down did not hold cpu and stop crystal");
    a_sub_disable_stops:
        assert property (reg_wr && reg_addr == 8'hC4 && reg_wdata[4] && quiet
            |-> ##[1:2] !sub_osc_en)
        else $error("sub oscillator still enabled after disable");
endmodule

bind oscsel_top oscsel_top_asserts #(.XTAL_LONG_CNT(XTAL_LONG_CNT), .SUB_LONG_CNT(SUB_LONG_CNT))
    u_chk (.mclk(mclk), .sys_rst(sys_rst), .pin_rst(pin_rst), .wdt_rst(wdt_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pd_enter(pd_enter), .int_ack_hi(int_ack_hi),
    .int_ack_lo(int_ack_lo), .return_from_interrupt(return_from_interrupt),
    .crystal_osc_en(crystal_osc_en), .sub_osc_en(sub_osc_en), .cpu_hold(cpu_hold),
    .high_prio_in_service(high_prio_in_service), .low_prio_in_service(low_prio_in_service));

// *** dv/tb_osc_source_select_warmup.sv ***
// Self-checking bench for the clock source block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_osc_source_select_warmup;
    reg mclk, sys_rst, pin_rst, wdt_rst, reg_wr, reg_rd, xtal_long_opt, sub_long_opt;
    reg pd_enter, pd_wake, int_ack_hi, int_ack_lo, return_from_interrupt;
    reg [7:0] reg_addr, reg_wdata, rdv;
    wire [7:0] reg_rdata;
    wire crystal_clk_in, sub_osc_clk_in, sys_clk_from_crystal, crystal_osc_en, sub_osc_en;
    wire cpu_hold, high_prio_in_service, low_prio_in_service, irq;
    integer error_cnt = 0;
    integer num_checks = 0;
    // Long warm-ups shortened to 16 edges so runs stay short
    oscsel_top #(.XTAL_LONG_CNT(16), .SUB_LONG_CNT(16)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .pin_rst(pin_rst), .wdt_rst(wdt_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .crystal_clk_in(crystal_clk_in), .sub_osc_clk_in(sub_osc_clk_in),
        .xtal_long_opt(xtal_long_opt), .sub_long_opt(sub_long_opt), .pd_enter(pd_enter),
        .pd_wake(pd_wake), .int_ack_hi(int_ack_hi), .int_ack_lo(int_ack_lo),
        .return_from_interrupt(return_from_interrupt),
        .sys_clk_from_crystal(sys_clk_from_crystal), .crystal_osc_en(crystal_osc_en),
        .sub_osc_en(sub_osc_en), .cpu_hold(cpu_hold), .high_prio_in_service(high_prio_in_service),
        .low_prio_in_service(low_prio_in_service), .irq(irq));
    oscsel_osc_model #(.XT_HALF(2), .SUB_HALF(2)) u_osc (.mclk(mclk), .xt_en(crystal_osc_en),
        .sub_en(sub_osc_en), .xt_clk(crystal_clk_in), .sub_clk(sub_osc_clk_in));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task cyc(input integer n);
    begin
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rdv = reg_rdata;
    end
    endtask
    task chk_rd(input [7:0] a, input [7:0] e);
    begin
        rd(a);
        `CHK("register", e, rdv)
    end
    endtask
    task chk_bit(input [7:0] a, input integer b, input e);
    begin
        rd(a);
        `CHK("register bit", e, rdv[b])
    end
    endtask
    // Polls a flag with a bounded count so a stuck flag cannot hang the run
    task wait_bit(input [7:0] a, input integer b, input e);
        integer i;
    begin
        i = 0;
        rd(a);
        while (rdv[b] !== e && i < 400)
        begin
            rd(a);
            i = i + 1;
        end
        `CHK("flag in time", e, rdv[b])
    end
    endtask
    // 0 enter, 1 wake, 2 ack high, 3 ack low, 4 return, 5 watchdog, 6 pin reset
    task pulse(input integer k);
    begin
        @(posedge mclk);
        case (k)
            0: pd_enter <= 1'b1;
            1: pd_wake <= 1'b1;
            2: int_ack_hi <= 1'b1;
            3: int_ack_lo <= 1'b1;
            4: return_from_interrupt <= 1'b1;
            5: wdt_rst <= 1'b1;
            default: pin_rst <= 1'b1;
        endcase
        @(posedge mclk);
        {pd_enter, pd_wake, int_ack_hi, int_ack_lo} <= 4'h0;
        {return_from_interrupt, wdt_rst, pin_rst} <= 3'h0;
    end
    endtask

    task report_and_stop;
    begin
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    task t_reset;
    begin
        chk_rd(8'hC4, 8'h81);
        chk_rd(8'hC5, 8'h10);
        `CHK("source", 1'b1, sys_clk_from_crystal)
    end
    endtask
    task t_source;
    begin
        wr(8'hC4, 8'h00);
        cyc(3);
        `CHK("source", 1'b0, sys_clk_from_crystal)
        chk_rd(8'hC4, 8'h41);
        wr(8'hC4, 8'h08);
        cyc(2);
        `CHK("crystal en", 1'b0, crystal_osc_en)
        chk_bit(8'hC5, 4, 1'b0);
        wr(8'hC4, 8'h88);
        chk_rd(8'hC4, 8'h49);
        wr(8'hC4, 8'h00);
        wr(8'hC4, 8'h80);
        chk_bit(8'hC4, 7, 1'b0);
        `CHK("crystal en", 1'b1, crystal_osc_en)
        wait_bit(8'hC5, 4, 1'b1);
        wr(8'hC4, 8'h80);
        cyc(3);
        `CHK("source", 1'b1, sys_clk_from_crystal)
        chk_rd(8'hC4, 8'h81);
    end
    endtask
    task t_irq;
    begin
        wr(8'hC7, 8'h07);
        wr(8'hC8, 8'h00);
        wr(8'hC4, 8'h88);
        cyc(1);
        `CHK("crystal en", 1'b1, crystal_osc_en)
        `CHK("irq", 1'b0, irq)
        chk_rd(8'hC6, 8'h04);
        wr(8'hC8, 8'h04);
        cyc(1);
        `CHK("irq", 1'b1, irq)
        wr(8'hC7, 8'h04);
        cyc(1);
        `CHK("irq", 1'b0, irq)
        chk_rd(8'hC7, 8'h00);
        chk_rd(8'hC8, 8'h04);
        chk_rd(8'hC9, 8'h00);
    end
    endtask
    task t_sub;
    begin
        wr(8'hC4, 8'h90);
        cyc(2);
        `CHK("sub en", 1'b0, sub_osc_en)
        chk_bit(8'hC5, 7, 1'b0);
        wr(8'hC4, 8'h80);
        wait_bit(8'hC5, 7, 1'b1);
        chk_rd(8'hC6, 8'h02);
    end
    endtask
    task t_service;
    begin
        pulse(2);
        pulse(3);
        cyc(1);
        `CHK("in service", 2'b11, {high_prio_in_service, low_prio_in_service})
        chk_bit(8'hC5, 6, 1'b1);
        pulse(4);
        cyc(1);
        `CHK("in service", 2'b01, {high_prio_in_service, low_prio_in_service})
        pulse(4);
        cyc(1);
        `CHK("in service", 2'b00, {high_prio_in_service, low_prio_in_service})
    end
    endtask
    task t_power_down;
    begin
        wr(8'hC4, 8'hA0);
        pulse(0);
        cyc(2);
        `CHK("crystal en", 1'b0, crystal_osc_en)
        chk_bit(8'hC5, 4, 1'b0);
        pulse(1);
        cyc(2);
        `CHK("hold", 1'b0, cpu_hold)
        `CHK("source", 1'b0, sys_clk_from_crystal)
        wait_bit(8'hC5, 4, 1'b1);
        cyc(3);
        `CHK("source", 1'b1, sys_clk_from_crystal)
        wr(8'hC4, 8'h80);
        pulse(0);
        cyc(2);
        pulse(1);
        cyc(4);
        `CHK("hold", 1'b1, cpu_hold)
        wait_bit(8'hC5, 4, 1'b1);
        cyc(2);
        `CHK("hold", 1'b0, cpu_hold)
    end
    endtask
    task t_resets;
    begin
        wr(8'hC4, 8'h20);
        cyc(3);
        chk_rd(8'hC4, 8'h61);
        pulse(5);
        chk_rd(8'hC4, 8'h61);
        chk_rd(8'hC5, 8'h00);
        pulse(6);
        chk_rd(8'hC4, 8'h81);
        wait_bit(8'hC5, 4, 1'b1);
    end
    endtask
    task t_opts;
    begin
        @(posedge mclk);
        xtal_long_opt <= 1'b0;
        sub_long_opt <= 1'b0;
        pulse(6);
        cyc(4 * 1024 - 16);
        chk_bit(8'hC5, 7, 1'b0);
        cyc(40);
        chk_bit(8'hC5, 7, 1'b1);
        cyc(4 * 4096 - 4 * 1024 - 60);
        chk_bit(8'hC5, 4, 1'b0);
        cyc(60);
        chk_bit(8'hC5, 4, 1'b1);
    end
    endtask

    initial
    begin
        {sys_rst, xtal_long_opt, sub_long_opt} = 3'h7;
        {pin_rst, wdt_rst, reg_wr, reg_rd, pd_enter, pd_wake} = 6'h00;
        {int_ack_hi, int_ack_lo, return_from_interrupt} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset;
        t_source;
        t_irq;
        t_sub;
        t_service;
        t_power_down;
        t_resets;
        t_opts;
        report_and_stop;
    end

    initial
    begin
        #4000000;
        error_cnt = error_cnt + 1;
        $display("wrong value run time expected end seen timeout");
        report_and_stop;
    end
endmodule

// *** verilog/oscsel_regs.vh ***
// Register map, field positions, reset values and warm-up counts of the clock source block
//
// Overview of operation
// [R1] Select bit 1 runs system clock from crystal; 0 runs it from RC oscillator.
// [R2] Writing select to 1 ignored unless crystal warm done and crystal enabled.
// [R3] Select bit set by power-on and pin reset, kept through watchdog reset.
// [R4] RC running status reads 0 on crystal, 1 on RC oscillator.
// [R5] RC status and resume select clear on power-on/pin reset, kept through watchdog.
// [R6] Resume with resume select 1 runs from RC; with 0 stalls until warm.
// [R7] Sub-oscillator disable bit stops the 32 kHz sub-oscillator.
// [R8] Crystal disable stops crystal; accepts 1 only while running from RC.
// [R9] Clearing crystal disable restarts crystal; warm done sets after warm-up count.
// [R10] Sub warm done sets after its delay, cleared while sub disable set.
// [R11] Sub warm-up delay is 1024 or 65536 sub clocks by option.
// [R12] Crystal warm done clears on power-down exit restart and on crystal disable.
// [R13] Crystal warm-up delay is 4096 or 65536 crystal clocks by option.
// [R14] Crystal warm done reads 1 after power-on reset.
// [R15] In-service bits set while servicing, cleared by matching return from interrupt.
// [R16] Mode register resets 10000xx1, watchdog reset keeps upper three bits.
// [R17] Warm-up options sampled at reset; counters count their own oscillator clocks.
`ifndef OSCSEL_REGS_VH
`define OSCSEL_REGS_VH

`define OSCSEL_ADDR_MODE 8'hC4
`define OSCSEL_ADDR_STATUS 8'hC5
`define OSCSEL_ADDR_IRQ_STAT 8'hC6
`define OSCSEL_ADDR_IRQ_CLR 8'hC7
`define OSCSEL_ADDR_IRQ_EN 8'hC8

`define OSCSEL_MODE_SEL_BIT 7
`define OSCSEL_MODE_RCRUN_BIT 6
`define OSCSEL_MODE_RESUME_BIT 5
`define OSCSEL_MODE_SUBDIS_BIT 4
`define OSCSEL_MODE_XDIS_BIT 3
`define OSCSEL_MODE_FIXED_BIT 0

`define OSCSEL_STAT_SUBUP_BIT 7
`define OSCSEL_STAT_HIP_BIT 6
`define OSCSEL_STAT_LIP_BIT 5
`define OSCSEL_STAT_XUP_BIT 4

`define OSCSEL_IRQ_XUP_BIT 0
`define OSCSEL_IRQ_SUBUP_BIT 1
`define OSCSEL_IRQ_REFUSE_BIT 2
`define OSCSEL_IRQ_W 3

`define OSCSEL_RST_SEL 1'b1
`define OSCSEL_RST_RCRUN 1'b0
`define OSCSEL_RST_RESUME 1'b0
`define OSCSEL_RST_SUBDIS 1'b0
`define OSCSEL_RST_XDIS 1'b0
`define OSCSEL_RST_XUP_POR 1'b1
`define OSCSEL_RST_IRQ 3'h0
`define OSCSEL_RST_RDATA 8'h00

`define OSCSEL_CNT_W 17
`define OSCSEL_XTAL_SHORT 17'h01000
`define OSCSEL_SUB_SHORT 17'h00400
`define OSCSEL_LONG 65536

`endif

// *** verilog/oscsel_top.v ***
// Clock source selection, oscillator disable and warm-up status registers
`timescale 1ns/1ns
`include "oscsel_regs.vh"
module oscsel_top
#(
    parameter XTAL_LONG_CNT = `OSCSEL_LONG,
    parameter SUB_LONG_CNT = `OSCSEL_LONG
)
(
    input wire mclk,
    input wire sys_rst,
    input wire pin_rst,
    input wire wdt_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire crystal_clk_in,
    input wire sub_osc_clk_in,
    input wire xtal_long_opt,
    input wire sub_long_opt,
    input wire pd_enter,
    input wire pd_wake,
    input wire int_ack_hi,
    input wire int_ack_lo,
    input wire return_from_interrupt,
    output reg sys_clk_from_crystal,
    output reg crystal_osc_en,
    output reg sub_osc_en,
    output reg cpu_hold,
    output reg high_prio_in_service,
    output reg low_prio_in_service,
    output wire irq
);
    localparam ST_RUN = 3'b001;
    localparam ST_PD = 3'b010;
    localparam ST_WAIT = 3'b100;

    // Pin and watchdog resets arrive as one-cycle pulses from the reset logic
    wire full_rst;
    wire any_rst;
    assign full_rst = sys_rst | pin_rst;
    assign any_rst = full_rst | wdt_rst;

    // Oscillator clock pins are asynchronous: three stages, a change counts on agreement
    wire [1:0] osc_pin;
    wire [1:0] osc_edge;
    assign osc_pin = {sub_osc_clk_in, crystal_clk_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_osc_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg filt_q;
            reg prev_q;
            always @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    filt_q <= 1'b0;
                    prev_q <= 1'b0;
                end
                else
                begin
                    s1_q <= osc_pin[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                    begin
                        filt_q <= s2_q;
                    end
                    prev_q <= filt_q;
                end
            end
            assign osc_edge[gi] = filt_q & ~prev_q;
        end
    endgenerate

    // Warm-up length options are straps, caught on each reset
    reg xtal_long_q;
    reg sub_long_q;
    always @(posedge mclk)
    begin
        if (any_rst)
        begin
            xtal_long_q <= xtal_long_opt; // [R17]
            sub_long_q <= sub_long_opt; // [R17]
        end
    end

    reg sel_q;
    reg sel_d;
    reg rcrun_q;
    reg rcrun_d;
    reg resume_q;
    reg resume_d;
    reg subdis_q;
    reg subdis_d;
    reg xdis_q;
    reg xdis_d;
    reg xup_q;
    reg xup_d;
    reg subup_q;
    reg subup_d;
    reg rc_hold_q;
    reg rc_hold_d;
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [`OSCSEL_IRQ_W-1:0] irq_stat_q;
    reg [`OSCSEL_IRQ_W-1:0] irq_en_q;
    reg [`OSCSEL_IRQ_W-1:0] irq_evt;
    reg refuse;
    wire xtal_done;
    wire sub_done;
    wire xtal_restart;
    wire wr_mode;
    wire wr_clr;
    wire wr_en;
    wire want_sel;
    wire want_xdis;

    assign wr_mode = reg_wr && (reg_addr == `OSCSEL_ADDR_MODE);
    assign wr_clr = reg_wr && (reg_addr == `OSCSEL_ADDR_IRQ_CLR);
    assign wr_en = reg_wr && (reg_addr == `OSCSEL_ADDR_IRQ_EN);
    assign want_sel = reg_wdata[`OSCSEL_MODE_SEL_BIT];
    assign want_xdis = reg_wdata[`OSCSEL_MODE_XDIS_BIT];

    // Crystal stops while disabled or powered down; pin and watchdog resets also rerun its warm-up
    assign xtal_restart = xdis_q | st_q[2'd1] | pin_rst | wdt_rst; // [R9] [R12]

    oscsel_warmup
    #(
        .START_RUN(1'b0),
        .LONG_CNT(XTAL_LONG_CNT)
    )
    u_xtal_warm
    (
        .mclk(mclk),
        .rst(sys_rst),
        .restart(xtal_restart),
        .osc_edge(osc_edge[0]),
        .long_sel(xtal_long_q),
        .short_cnt(`OSCSEL_XTAL_SHORT), // [R13]
        .done_pulse(xtal_done)
    );

    oscsel_warmup
    #(
        .START_RUN(1'b1),
        .LONG_CNT(SUB_LONG_CNT)
    )
    u_sub_warm
    (
        .mclk(mclk),
        .rst(sys_rst),
        .restart(subdis_q | pin_rst | wdt_rst),
        .osc_edge(osc_edge[1]),
        .long_sel(sub_long_q),
        .short_cnt(`OSCSEL_SUB_SHORT), // [R11]
        .done_pulse(sub_done)
    );

    // Power-down sequencing and the clock-source decision
    always @*
    begin
        st_d = st_q;
        rc_hold_d = rc_hold_q;
        case (st_q)
            ST_RUN:
            begin
                if (pd_enter)
                begin
                    st_d = ST_PD;
                end
            end
            ST_PD:
            begin
                if (pd_wake)
                begin
                    if (resume_q)
                    begin
                        st_d = ST_RUN; // [R6]
                        rc_hold_d = 1'b1;
                    end
                    else
                    begin
                        st_d = ST_WAIT; // [R6]
                    end
                end
            end
            ST_WAIT:
            begin
                if (xup_q)
                begin
                    st_d = ST_RUN;
                end
            end
            default:
            begin
                st_d = ST_RUN;
            end
        endcase
        // RC stands in until the restarted crystal has warmed up
        if (xup_q)
        begin
            rc_hold_d = 1'b0;
        end
    end

    always @*
    begin
        sel_d = sel_q;
        resume_d = resume_q;
        subdis_d = subdis_q;
        xdis_d = xdis_q;
        refuse = 1'b0;
        if (wr_mode)
        begin
            resume_d = reg_wdata[`OSCSEL_MODE_RESUME_BIT];
            subdis_d = reg_wdata[`OSCSEL_MODE_SUBDIS_BIT]; // [R7]
            // Disable takes effect only while the RC status is set, so one write can both stop and select the crystal
            if (!want_xdis || rcrun_q)
            begin
                xdis_d = want_xdis; // [R8]
            end
            else
            begin
                refuse = 1'b1;
            end
            // Checks use present flags, so one write cannot enable and select together
            if (!want_sel)
            begin
                sel_d = 1'b0;
            end
            else if (xup_q && !xdis_q)
            begin
                sel_d = 1'b1; // [R2]
            end
            else
            begin
                refuse = 1'b1; // [R2]
            end
        end
        rcrun_d = ~(sel_q & ~rc_hold_q); // [R1] [R4]
    end

    // Warm-done flags: the finishing pulse sets, disable or restart clears
    always @*
    begin
        xup_d = xup_q;
        if (xtal_restart)
        begin
            xup_d = 1'b0; // [R12]
        end
        else if (xtal_done)
        begin
            xup_d = 1'b1; // [R9]
        end
        subup_d = subup_q;
        if (subdis_q | pin_rst | wdt_rst)
        begin
            subup_d = 1'b0; // [R10]
        end
        else if (sub_done)
        begin
            subup_d = 1'b1; // [R10]
        end
    end

    always @(posedge mclk)
    begin
        if (full_rst)
        begin
            sel_q <= `OSCSEL_RST_SEL; // [R3] [R16]
            rcrun_q <= `OSCSEL_RST_RCRUN; // [R5]
            resume_q <= `OSCSEL_RST_RESUME; // [R5]
        end
        else if (!wdt_rst)
        begin
            sel_q <= sel_d;
            rcrun_q <= rcrun_d;
            resume_q <= resume_d;
        end
    end

    always @(posedge mclk)
    begin
        if (any_rst)
        begin
            subdis_q <= `OSCSEL_RST_SUBDIS; // [R16]
            xdis_q <= `OSCSEL_RST_XDIS; // [R16]
            rc_hold_q <= 1'b0;
            st_q <= ST_RUN;
            subup_q <= 1'b0;
            xup_q <= sys_rst ? `OSCSEL_RST_XUP_POR : 1'b0; // [R14]
        end
        else
        begin
            subdis_q <= subdis_d;
            xdis_q <= xdis_d;
            rc_hold_q <= rc_hold_d;
            st_q <= st_d;
            subup_q <= subup_d;
            xup_q <= xup_d;
        end
    end

    // In-service bits: a new entry wins over a return in the same cycle
    always @(posedge mclk)
    begin
        if (any_rst)
        begin
            high_prio_in_service <= 1'b0;
            low_prio_in_service <= 1'b0;
        end
        else
        begin
            high_prio_in_service <= int_ack_hi |
                (high_prio_in_service & ~return_from_interrupt); // [R15]
            low_prio_in_service <= int_ack_lo |
                (low_prio_in_service &
                ~(return_from_interrupt & ~high_prio_in_service)); // [R15]
        end
    end

    // Sticky event bits; a set in the clearing cycle is kept
    always @*
    begin
        irq_evt = {`OSCSEL_IRQ_W{1'b0}};
        irq_evt[`OSCSEL_IRQ_XUP_BIT] = xup_d & ~xup_q;
        irq_evt[`OSCSEL_IRQ_SUBUP_BIT] = subup_d & ~subup_q;
        irq_evt[`OSCSEL_IRQ_REFUSE_BIT] = refuse;
    end

    always @(posedge mclk)
    begin
        if (any_rst)
        begin
            irq_stat_q <= `OSCSEL_RST_IRQ;
            irq_en_q <= `OSCSEL_RST_IRQ;
        end
        else
        begin
            irq_stat_q <= irq_evt |
                (irq_stat_q & ~(wr_clr ? reg_wdata[`OSCSEL_IRQ_W-1:0] : `OSCSEL_RST_IRQ));
            if (wr_en)
            begin
                irq_en_q <= reg_wdata[`OSCSEL_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    // Read data stand only in the cycle after the strobe
    reg [7:0] rd_mux;
    always @*
    begin
        rd_mux = 8'h00;
        case (reg_addr)
            `OSCSEL_ADDR_MODE:
            begin
                rd_mux[`OSCSEL_MODE_SEL_BIT] = sel_q;
                rd_mux[`OSCSEL_MODE_RCRUN_BIT] = rcrun_q; // [R4]
                rd_mux[`OSCSEL_MODE_RESUME_BIT] = resume_q;
                rd_mux[`OSCSEL_MODE_SUBDIS_BIT] = subdis_q;
                rd_mux[`OSCSEL_MODE_XDIS_BIT] = xdis_q;
                rd_mux[`OSCSEL_MODE_FIXED_BIT] = 1'b1; // [R16]
            end
            `OSCSEL_ADDR_STATUS:
            begin
                rd_mux[`OSCSEL_STAT_SUBUP_BIT] = subup_q;
                rd_mux[`OSCSEL_STAT_HIP_BIT] = high_prio_in_service;
                rd_mux[`OSCSEL_STAT_LIP_BIT] = low_prio_in_service;
                rd_mux[`OSCSEL_STAT_XUP_BIT] = xup_q;
            end
            `OSCSEL_ADDR_IRQ_STAT:
            begin
                rd_mux[`OSCSEL_IRQ_W-1:0] = irq_stat_q;
            end
            `OSCSEL_ADDR_IRQ_EN:
            begin
                rd_mux[`OSCSEL_IRQ_W-1:0] = irq_en_q;
            end
            default:
            begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= `OSCSEL_RST_RDATA;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_mux : `OSCSEL_RST_RDATA;
        end
    end

    // Clock and oscillator controls leave from flip-flops
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sys_clk_from_crystal <= 1'b1;
            crystal_osc_en <= 1'b1;
            sub_osc_en <= 1'b1;
            cpu_hold <= 1'b0;
        end
        else
        begin
            sys_clk_from_crystal <= ~rcrun_q; // [R1]
            crystal_osc_en <= ~xdis_q & ~st_q[2'd1]; // [R8] [R9]
            sub_osc_en <= ~subdis_q; // [R7]
            cpu_hold <= st_q[2'd1] | st_q[2'd2]; // [R6]
        end
    end
endmodule

// *** verilog/oscsel_warmup.v ***
// Warm-up counter: counts qualified oscillator edges up to a selectable target
`timescale 1ns/1ns
`include "oscsel_regs.vh"
module oscsel_warmup
#(
    parameter START_RUN = 1'b1,
    parameter LONG_CNT = `OSCSEL_LONG
)
(
    input wire mclk,
    input wire rst,
    input wire restart,
    input wire osc_edge,
    input wire long_sel,
    input wire [`OSCSEL_CNT_W-1:0] short_cnt,
    output reg done_pulse
);
    reg [`OSCSEL_CNT_W-1:0] cnt_q;
    reg run_q;
    wire [`OSCSEL_CNT_W-1:0] target;
    wire [`OSCSEL_CNT_W-1:0] cnt_inc;

    assign target = long_sel ? LONG_CNT[`OSCSEL_CNT_W-1:0] : short_cnt;
    assign cnt_inc = cnt_q + {{(`OSCSEL_CNT_W-1){1'b0}}, 1'b1};

    // Restart holds the count at zero, so a stopped oscillator never finishes
    always @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_q <= {`OSCSEL_CNT_W{1'b0}};
            run_q <= START_RUN;
            done_pulse <= 1'b0;
        end
        else if (restart)
        begin
            cnt_q <= {`OSCSEL_CNT_W{1'b0}};
            run_q <= 1'b1;
            done_pulse <= 1'b0;
        end
        else if (run_q && osc_edge)
        begin
            cnt_q <= cnt_inc;
            done_pulse <= (cnt_inc == target); // [R17]
            run_q <= (cnt_inc != target);
        end
        else
        begin
            done_pulse <= 1'b0;
        end
    end
endmodule
